// [cbc_unit.sv]
/*
  Compare, branch, call, string compare and float conversion unit.
  Assumes one request at a time from the sequencer and a memory port
  that answers each access with a one-cycle ready, possibly with fault.
*/
`timescale 1ns/1ps
// How it works
// - Conditional branch loads target when flags match codes 8,9,B,C,D,E,F.
// - Float branch: code 0 any exception, code 1 bad result; others reserved.
// - Call pushes next instruction address on given stack, then jumps.
// - Faulting call stack write leaves stack pointer untouched and reports fault.
// - Supervisor call vector sits at 400 hex plus eight times operand.
// - Supervisor call pushes SSW, PSW, PC; loads PC, SSW; clears PSW.
// - String compare walks count and both addresses while bytes match.
// - Fetched bytes are sign-extended to words before comparing.
// - Exhausted count gives Z only; mismatch flags from second minus first.
// - Faults leave string registers at progress so restart resumes.
// - Integer compares set flags from destination minus source, no writes.
// - Short immediates are sign-extended sixteen-bit values.
// - Float compares: N for less or unordered, Z equal or unordered.
// - Double to single allows same register; keeps trap PC and destination.
// - Plain double to word follows PSW rounding mode.
// - Word conversion flags invalid out of range, inexact when not whole (rounding form: when fraction is not exactly half).
// - Conversion traps keep the trapping PC available.
// - Rounding conversion adds signed half, truncates, ignores PSW mode.
module cbc_unit (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  req_valid,
  input  wire cbc_pkg::cbc_req_t     req,
  output logic                       busy,
  output cbc_pkg::cbc_out_t          res,
  output logic [31:0]                str_count,
  output logic [31:0]                str_addr1,
  output logic [31:0]                str_addr2,
  output cbc_pkg::cbc_mem_req_t      mem_req,
  input  wire cbc_pkg::cbc_mem_rsp_t mem_rsp
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CALL, ST_PUSH, ST_VEC, ST_STR_CHK, ST_STR_RD1, ST_STR_RD2
  } cbc_state_t;

  typedef struct packed {
    cbc_state_t            fsm;
    cbc_pkg::cbc_req_t     rq;
    logic [1:0]            idx;
    logic [31:0]           byte1;
    cbc_pkg::cbc_out_t     out;
    cbc_pkg::cbc_mem_req_t mem;
  } cbc_reg_t;

  cbc_reg_t s;
  cbc_reg_t next_s;

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  // C is the borrow of dst - src, so it reads as unsigned dst below src
  function automatic cbc_pkg::cbc_cc_t sub_cc(input logic [31:0] dst, input logic [31:0] src);
    logic [32:0]       d;
    cbc_pkg::cbc_cc_t  f;
    d   = {1'b0, dst} - {1'b0, src};
    f.c = d[32];
    f.n = d[31];
    f.z = (d[31:0] == 32'h0);
    f.v = (dst[31] != src[31]) && (d[31] != dst[31]);
    return f;
  endfunction

  function automatic cbc_pkg::cbc_cc_t fcmp_cc(input logic sd, input logic [62:0] md, input logic nd,
                                               input logic ss, input logic [62:0] ms, input logic ns);
    logic              un;
    logic              zz;
    logic              eq;
    logic              lt;
    cbc_pkg::cbc_cc_t  f;
    un = nd | ns;
    zz = (md == 63'h0) && (ms == 63'h0);
    eq = zz || (sd == ss && md == ms);
    if (sd != ss) begin
      lt = sd && !zz;
    end else begin
      lt = sd ? (md > ms) : (md < ms);
    end
    f.n = lt | un;
    f.z = (eq & !un) | un;
    f.v = 1'b0;
    f.c = 1'b0;
    return f;
  endfunction

  function automatic logic [31:0] sext8(input logic [31:0] w);
    return {{24{w[7]}}, w[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Converters fed straight from the request
  // ----------------------------------------------------------------
  logic [1:0]  cv_mode;
  logic        cv_half;
  logic [31:0] cv_result;
  logic        cv_invalid;
  logic        cv_inexact;

  always_comb begin
    cv_mode = req.c[cbc_pkg::PSW_RM_LSB +: 2];
    cv_half = 1'b0;
    if (req.op == cbc_pkg::OP_CNVTDW) begin
      cv_mode = cbc_pkg::RM_ZERO;
    end
    if (req.op == cbc_pkg::OP_CNVRDW) begin
      cv_mode = cbc_pkg::RM_ZERO;
      cv_half = 1'b1;
    end
  end

  cbc_f2w u_f2w (
    .value     (req.fa),
    .rmode     (cv_mode),
    .half_away (cv_half),
    .result    (cv_result),
    .invalid   (cv_invalid),
    .inexact   (cv_inexact)
  );

  // Double to single: round to nearest even, flush tiny results to zero
  logic [11:0]         ds_exp;
  logic [31:0]         ds_val;
  cbc_pkg::cbc_fexc_t  ds_exc;
  logic                ds_lost;
  logic                ds_up;

  always_comb begin
    ds_exp  = {1'b0, req.fa[62:52]} - {1'b0, cbc_pkg::DBL_BIAS} + {1'b0, cbc_pkg::SGL_BIAS};
    ds_lost = |req.fa[28:0];
    ds_up   = req.fa[28] & ((|req.fa[27:0]) | req.fa[29]);
    ds_exc  = '0;
    ds_val  = {req.fa[63], ds_exp[7:0], req.fa[51:29]} + {31'h0, ds_up};
    if (req.fa[62:52] == cbc_pkg::DBL_EXP_MAX) begin
      ds_val = {req.fa[63], 8'hFF, req.fa[51:29] | {22'h0, |req.fa[51:0] & !(|req.fa[51:29])}};
      ds_exc.float_invalid_flag = (|req.fa[50:0]) & !req.fa[51];
    end else if (req.fa[62:0] == 63'h0) begin
      ds_val = {req.fa[63], 31'h0};
    end else if ($signed(ds_exp) <= 12'sd0) begin
      ds_val = {req.fa[63], 31'h0};
      ds_exc.float_underflow_flag = 1'b1;
      ds_exc.float_inexact_flag   = 1'b1;
    end else if ($signed(ds_exp) >= 12'sd255 || ds_val[30:23] == 8'hFF) begin
      ds_val = {req.fa[63], 8'hFF, 23'h0};
      ds_exc.float_overflow_flag = 1'b1;
      ds_exc.float_inexact_flag  = 1'b1;
    end else begin
      ds_exc.float_inexact_flag = ds_lost;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  cbc_pkg::cbc_cc_t  int_cc;
  logic [31:0]       int_src;
  logic              br_take;
  logic [31:0]       trap_vec;

  always_comb begin
    int_src = req.a;
    if (req.op == cbc_pkg::OP_CMPI && req.imm_short) begin
      int_src = {{16{req.a[15]}}, req.a[15:0]};
    end
    if (req.op == cbc_pkg::OP_CMPQ) begin
      int_src = {28'h0, req.a[3:0]};
    end
    int_cc = sub_cc(req.b, int_src);
    case (req.cond)
      cbc_pkg::COND_ALWAYS: br_take = 1'b1;
      cbc_pkg::COND_NC:     br_take = !res.cc.c;
      cbc_pkg::COND_C:      br_take = res.cc.c;
      cbc_pkg::COND_V:      br_take = res.cc.v;
      cbc_pkg::COND_NV:     br_take = !res.cc.v;
      cbc_pkg::COND_NEG:    br_take = res.cc.n & !res.cc.z;
      cbc_pkg::COND_NN:     br_take = !res.cc.n;
      cbc_pkg::COND_UNORD:  br_take = res.cc.n & res.cc.z;
      default:              br_take = 1'b0;
    endcase
    if (req.op == cbc_pkg::OP_BRF) begin
      case (req.cond)
        cbc_pkg::FCOND_ANY: br_take = req.f_any;
        cbc_pkg::FCOND_BAD: br_take = req.f_bad;
        default:            br_take = 1'b0;
      endcase
    end
    trap_vec = cbc_pkg::TRAP_BASE + ({25'h0, s.rq.tnum} << cbc_pkg::TRAP_SHIFT);
  end

  always_comb begin
    next_s = s;
    next_s.out.done      = 1'b0;
    next_s.out.fault     = 1'b0;
    next_s.out.cc_we     = 1'b0;
    next_s.out.fexc_we   = 1'b0;
    next_s.out.pc_load   = 1'b0;
    next_s.out.sp_we     = 1'b0;
    next_s.out.ssp_we    = 1'b0;
    next_s.out.ssw_load  = 1'b0;
    next_s.out.psw_clear = 1'b0;
    next_s.out.wd_we     = 1'b0;
    next_s.out.str_we    = 1'b0;
    case (s.fsm)
      ST_IDLE: begin
        if (req_valid) begin
          next_s.rq  = req;
          next_s.idx = 2'h0;
          case (req.op)
            cbc_pkg::OP_CMPW, cbc_pkg::OP_CMPI, cbc_pkg::OP_CMPQ: begin
              next_s.out.cc    = int_cc;
              next_s.out.cc_we = 1'b1;
              next_s.out.done  = 1'b1;
            end
            cbc_pkg::OP_CMPD: begin
              next_s.out.cc    = fcmp_cc(req.fb[63], req.fb[62:0],
                                         req.fb[62:52] == cbc_pkg::DBL_EXP_MAX && |req.fb[51:0],
                                         req.fa[63], req.fa[62:0],
                                         req.fa[62:52] == cbc_pkg::DBL_EXP_MAX && |req.fa[51:0]);
              next_s.out.cc_we = 1'b1;
              next_s.out.done  = 1'b1;
            end
            cbc_pkg::OP_CMPS: begin
              next_s.out.cc    = fcmp_cc(req.fb[31], {req.fb[30:0], 32'h0},
                                         req.fb[30:23] == 8'hFF && |req.fb[22:0],
                                         req.fa[31], {req.fa[30:0], 32'h0},
                                         req.fa[30:23] == 8'hFF && |req.fa[22:0]);
              next_s.out.cc_we = 1'b1;
              next_s.out.done  = 1'b1;
            end
            cbc_pkg::OP_BRC, cbc_pkg::OP_BRF: begin
              next_s.out.pc_load  = br_take;
              next_s.out.pc_value = req.target;
              next_s.out.done     = 1'b1;
            end
            cbc_pkg::OP_CALL: begin
              next_s.mem = '{valid: 1'b1, write: 1'b1, addr: req.a - cbc_pkg::WORD_BYTES,
                             wdata: req.pc_next};
              next_s.fsm = ST_CALL;
            end
            cbc_pkg::OP_CALLS: begin
              next_s.mem = '{valid: 1'b1, write: 1'b1, addr: req.a - cbc_pkg::WORD_BYTES,
                             wdata: req.b};
              next_s.fsm = ST_PUSH;
            end
            cbc_pkg::OP_CMPC: begin
              next_s.fsm = ST_STR_CHK;
            end
            // operand already captured, so source may equal destination
            cbc_pkg::OP_CNVDS: begin
              next_s.out.wd_value   = ds_val;
              next_s.out.wd_we      = 1'b1;
              next_s.out.fexc       = ds_exc;
              next_s.out.fexc_we    = 1'b1;
              next_s.out.fp_orig    = req.fb[31:0];
              next_s.out.fp_trap_pc = req.pc;
              next_s.out.done       = 1'b1;
            end
            default: begin
              next_s.out.wd_value = cv_result;
              next_s.out.wd_we    = 1'b1;
              next_s.out.fexc     = '{float_inexact_flag: cv_inexact, float_underflow_flag: 1'b0,
                                      float_overflow_flag: 1'b0, float_invalid_flag: cv_invalid};
              next_s.out.fexc_we  = 1'b1;
              next_s.out.fp_trap_pc = req.pc;
              next_s.out.done       = 1'b1;
            end
          endcase
        end
      end
      ST_CALL: begin
        if (mem_rsp.ready) begin
          next_s.mem.valid = 1'b0;
          next_s.fsm       = ST_IDLE;
          next_s.out.done  = 1'b1;
          if (mem_rsp.fault) begin
            next_s.out.fault = 1'b1;
          end else begin
            next_s.out.sp_value = s.mem.addr;
            next_s.out.sp_we    = 1'b1;
            next_s.out.pc_value = s.rq.target;
            next_s.out.pc_load  = 1'b1;
          end
        end
      end
      ST_PUSH: begin
        if (mem_rsp.ready) begin
          next_s.mem.addr  = s.mem.addr - cbc_pkg::WORD_BYTES;
          next_s.mem.wdata = (s.idx == 2'h0) ? s.rq.c : s.rq.pc_next;
          next_s.idx       = s.idx + 2'h1;
          if (mem_rsp.fault) begin
            next_s.mem.valid = 1'b0;
            next_s.out.fault = 1'b1;
            next_s.out.done  = 1'b1;
            next_s.fsm       = ST_IDLE;
          end else if (s.idx == 2'(cbc_pkg::PUSH_WORDS - 1)) begin
            next_s.out.sp_value = s.mem.addr;
            next_s.mem.write    = 1'b0;
            next_s.mem.addr     = trap_vec;
            next_s.idx          = 2'h0;
            next_s.fsm          = ST_VEC;
          end
        end
      end
      ST_VEC: begin
        if (mem_rsp.ready) begin
          next_s.mem.addr = s.mem.addr + cbc_pkg::WORD_BYTES;
          next_s.idx = s.idx + 2'h1;
          if (s.idx == 2'h0) begin
            next_s.out.pc_value = mem_rsp.rdata;
          end else begin
            next_s.out.ssw_value = mem_rsp.rdata;
          end
          if (mem_rsp.fault || s.idx == 2'(cbc_pkg::VEC_WORDS - 1)) begin
            next_s.mem.valid     = 1'b0;
            next_s.out.fault     = mem_rsp.fault;
            next_s.out.ssp_we    = !mem_rsp.fault;
            next_s.out.pc_load   = !mem_rsp.fault;
            next_s.out.ssw_load  = !mem_rsp.fault;
            next_s.out.psw_clear = !mem_rsp.fault;
            next_s.out.done      = 1'b1;
            next_s.fsm           = ST_IDLE;
          end
        end
      end
      ST_STR_CHK: begin
        if (s.rq.a == 32'h0) begin
          next_s.out.cc     = '{c: 1'b0, v: 1'b0, z: 1'b1, n: 1'b0};
          next_s.out.cc_we  = 1'b1;
          next_s.out.str_we = 1'b1;
          next_s.out.done   = 1'b1;
          next_s.fsm        = ST_IDLE;
        end else begin
          next_s.mem = '{valid: 1'b1, write: 1'b0, addr: s.rq.b, wdata: cbc_pkg::RESET_WORD};
          next_s.fsm = ST_STR_RD1;
        end
      end
      ST_STR_RD1: begin
        if (mem_rsp.ready) begin
          next_s.byte1    = sext8(mem_rsp.rdata);
          next_s.mem.addr = s.rq.c;
          next_s.fsm      = ST_STR_RD2;
        end
      end
      ST_STR_RD2: begin
        if (mem_rsp.ready) begin
          next_s.mem.valid = 1'b0;
          next_s.fsm       = ST_STR_CHK;
          if (!mem_rsp.fault && sext8(mem_rsp.rdata) == s.byte1) begin
            next_s.rq.a = s.rq.a - 32'h1;
            next_s.rq.b = s.rq.b + 32'h1;
            next_s.rq.c = s.rq.c + 32'h1;
          end else if (!mem_rsp.fault) begin
            next_s.out.cc     = sub_cc(sext8(mem_rsp.rdata), s.byte1);
            next_s.out.cc_we  = 1'b1;
            next_s.out.str_we = 1'b1;
            next_s.out.done   = 1'b1;
            next_s.fsm        = ST_IDLE;
          end
        end
        if (mem_rsp.ready && mem_rsp.fault) begin
          next_s.mem.valid  = 1'b0;
          next_s.out.fault  = 1'b1;
          next_s.out.str_we = 1'b1;
          next_s.out.done   = 1'b1;
          next_s.fsm        = ST_IDLE;
        end
      end
      default: begin
        next_s.fsm = ST_IDLE;
      end
    endcase
    if (s.fsm == ST_STR_RD1 && mem_rsp.ready && mem_rsp.fault) begin
      next_s.mem.valid  = 1'b0;
      next_s.out.fault  = 1'b1;
      next_s.out.str_we = 1'b1;
      next_s.out.done   = 1'b1;
      next_s.fsm        = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy      = (s.fsm != ST_IDLE);
  assign res       = s.out;
  assign str_count = s.rq.a;
  assign str_addr1 = s.rq.b;
  assign str_addr2 = s.rq.c;
  assign mem_req   = s.mem;

endmodule // cbc_unit

// [cbc_pkg.sv]
/*
  Shared types and constants of the compare, branch and convert unit.
  Assumes the sequencer decodes instructions and hands over operands.
*/
package cbc_pkg;

  typedef enum logic [3:0] {
    OP_CMPW, OP_CMPI, OP_CMPQ, OP_CMPS, OP_CMPD, OP_BRC, OP_BRF, OP_CALL,
    OP_CALLS, OP_CMPC, OP_CNVDS, OP_CNVDW, OP_CNVRDW, OP_CNVTDW
  } cbc_op_t;

  // ----------------------------------------------------------------
  // Condition codes
  // ----------------------------------------------------------------
  localparam logic [3:0] COND_ALWAYS = 4'h0;
  localparam logic [3:0] COND_NC     = 4'h8;
  localparam logic [3:0] COND_C      = 4'h9;
  localparam logic [3:0] COND_V      = 4'hB;
  localparam logic [3:0] COND_NV     = 4'hC;
  localparam logic [3:0] COND_NEG    = 4'hD;
  localparam logic [3:0] COND_NN     = 4'hE;
  localparam logic [3:0] COND_UNORD  = 4'hF;
  localparam logic [3:0] FCOND_ANY   = 4'h0;
  localparam logic [3:0] FCOND_BAD   = 4'h1;

  // ----------------------------------------------------------------
  // Addresses, layouts, rounding
  // ----------------------------------------------------------------
  localparam logic [31:0] TRAP_BASE   = 32'h0000_0400;
  localparam int          TRAP_SHIFT  = 3;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam int          PUSH_WORDS  = 3;
  localparam int          VEC_WORDS   = 2;
  localparam int          PSW_RM_LSB  = 0;
  localparam logic [1:0]  RM_NEAREST  = 2'h0;
  localparam logic [1:0]  RM_POS      = 2'h1;
  localparam logic [1:0]  RM_NEG      = 2'h2;
  localparam logic [1:0]  RM_ZERO     = 2'h3;
  localparam logic [10:0] DBL_BIAS    = 11'h3FF;
  localparam logic [10:0] SGL_BIAS    = 11'h07F;
  localparam logic [10:0] DBL_EXP_MAX = 11'h7FF;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

  typedef struct packed { logic c; logic v; logic z; logic n; } cbc_cc_t;
  typedef struct packed {
    logic float_inexact_flag;
    logic float_underflow_flag;
    logic float_overflow_flag;
    logic float_invalid_flag;
  } cbc_fexc_t;

  typedef struct packed {
    cbc_op_t     op;
    logic [3:0]  cond;
    logic        imm_short;
    logic [6:0]  tnum;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [63:0] fa;
    logic [63:0] fb;
    logic [31:0] pc;
    logic [31:0] pc_next;
    logic [31:0] target;
    logic        f_any;
    logic        f_bad;
  } cbc_req_t;

  typedef struct packed {
    logic valid; logic write; logic [31:0] addr; logic [31:0] wdata;
  } cbc_mem_req_t;
  typedef struct packed { logic ready; logic fault; logic [31:0] rdata; } cbc_mem_rsp_t;

  typedef struct packed {
    logic        done;
    logic        fault;
    logic        cc_we;
    cbc_cc_t     cc;
    logic        fexc_we;
    cbc_fexc_t   fexc;
    logic        pc_load;
    logic [31:0] pc_value;
    logic        sp_we;
    logic        ssp_we;
    logic [31:0] sp_value;
    logic        ssw_load;
    logic [31:0] ssw_value;
    logic        psw_clear;
    logic        wd_we;
    logic [31:0] wd_value;
    logic        str_we;
    logic [31:0] fp_trap_pc;
    logic [31:0] fp_orig;
  } cbc_out_t;

endpackage

// [cbc_f2w.sv]
/*
  Double to signed word converter, purely combinational.
  Assumes IEEE double input; round mode and half-away select from the caller.
*/
`timescale 1ns/1ps
module cbc_f2w (
  input  wire logic [63:0] value,
  input  wire logic [1:0]  rmode,
  input  wire logic        half_away,
  output logic      [31:0] result,
  output logic             invalid,
  output logic             inexact
);
  logic        sign;
  logic [10:0] expo;
  logic [52:0] mant;
  logic [11:0] ue;
  logic [116:0] fix;
  logic [32:0] ipart;
  logic        half;
  logic        rest;
  logic        inc;
  logic [32:0] mag;

  always_comb begin
    sign  = value[63];
    expo  = value[62:52];
    mant  = {1'b1, value[51:0]};
    ue    = {1'b0, expo} - {1'b0, cbc_pkg::DBL_BIAS};
    fix   = '0;
    ipart = '0;
    half  = 1'b0;
    rest  = 1'b0;
    // Values below a quarter only leave a sticky bit
    if (expo == 11'h000) begin
      rest = |value[51:0];
    end else if ($signed(ue) < -12'sd2) begin
      rest = 1'b1;
    end else if ($signed(ue) < 12'sd33) begin
      fix   = {mant, 64'h0} >> (7'd52 - 7'(ue + 12'd0));
      ipart = fix[96:64];
      half  = fix[63];
      rest  = |fix[62:0];
    end
    case (rmode)
      cbc_pkg::RM_NEAREST: inc = half & (rest | ipart[0]);
      cbc_pkg::RM_POS:     inc = !sign & (half | rest);
      cbc_pkg::RM_NEG:     inc = sign & (half | rest);
      default:             inc = 1'b0;
    endcase
    if (half_away) begin
      inc     = half;
      inexact = !half | rest;
    end else begin
      inexact = half | rest;
    end
    mag = ipart + {32'h0, inc};
    invalid = (expo == cbc_pkg::DBL_EXP_MAX) || ($signed(ue) >= 12'sd33) ||
              (!sign && mag > 33'h0_7FFF_FFFF) || (sign && mag > 33'h0_8000_0000);
    if (invalid) begin
      inexact = 1'b0;
    end
    result = sign ? 32'(-mag) : mag[31:0];
  end
endmodule // cbc_f2w

// [cbc_chk_props.sv]
/* Port checker for cbc_unit.
   Assumes one clock and a synchronous reset; bound at the foot. */
`timescale 1ns/1ps
module cbc_chk (
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  req_valid,
  input wire cbc_pkg::cbc_req_t     req,
  input wire logic                  busy,
  input wire cbc_pkg::cbc_out_t     res,
  input wire cbc_pkg::cbc_mem_req_t mem_req,
  input wire cbc_pkg::cbc_mem_rsp_t mem_rsp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_take(cbc_pkg::cbc_op_t o);
    req_valid && !busy && req.op == o;
  endsequence
  AST_CMPW_Z:
    assert property (s_take(cbc_pkg::OP_CMPW) |=> res.done && res.cc_we && res.cc.z == ($past(req.a) == $past(req.b)))
    else $error("compare zero flag wrong");
  AST_CMP_NO_WRITE:
    assert property (s_take(cbc_pkg::OP_CMPI) |=> res.done && !res.wd_we && !res.pc_load && !res.sp_we)
    else $error("compare wrote state");
  AST_BRC_CARRY:
    assert property (s_take(cbc_pkg::OP_BRC) ##0 (req.cond == cbc_pkg::COND_C) |=> res.pc_load == $past(res.cc.c))
    else $error("carry branch wrong");
  AST_BRF_RSVD:
    assert property (s_take(cbc_pkg::OP_BRF) ##0 (req.cond > 4'h1) |=> res.done && !res.pc_load)
    else $error("reserved float branch taken");
  AST_CALL_PUSH:
    assert property (s_take(cbc_pkg::OP_CALL) |=> mem_req.valid && mem_req.write &&
      mem_req.addr == $past(req.a) - cbc_pkg::WORD_BYTES && mem_req.wdata == $past(req.pc_next))
    else $error("call push wrong");
  AST_FAULT_KEEP:
    assert property (res.fault |-> res.done && !res.sp_we && !res.ssp_we && !res.pc_load)
    else $error("fault changed state");
  AST_MEM_HOLD:
    assert property (mem_req.valid && !mem_rsp.ready |=> mem_req.valid && $stable(mem_req.addr))
    else $error("memory request dropped");
  AST_CMPC_EMPTY:
    assert property (s_take(cbc_pkg::OP_CMPC) ##0 (req.a == 32'h0) |-> ##[1:4] (res.done && res.cc == 4'h2))
    else $error("empty string flags wrong");
endmodule // cbc_chk
bind cbc_unit cbc_chk u_cbc_chk (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
  .busy(busy), .res(res), .mem_req(mem_req), .mem_rsp(mem_rsp));

// [cbc_mem.sv]
/* Memory partner: 256-byte array, set latency, one faulting address.
   Assumes word accesses little endian; high address bits alias. */
`timescale 1ns/1ps
module cbc_mem (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire cbc_pkg::cbc_mem_req_t mem_req,
  output cbc_pkg::cbc_mem_rsp_t      mem_rsp,
  input  wire logic [1:0]            lat,
  input  wire logic [31:0]           fault_addr
);
  logic [7:0] mem [256];
  logic [1:0] cnt;
  logic [7:0] a;
  assign a = mem_req.addr[7:0];
  always @(posedge ref_clk) begin
    mem_rsp.ready <= 1'b0;
    // Released data toggles so stale data never passes for an answer
    mem_rsp.rdata <= ~mem_rsp.rdata;
    if (reset) begin
      mem_rsp <= '0;
      cnt <= 2'h0;
    end else if (!mem_req.valid || mem_rsp.ready) cnt <= 2'h0;
    else if (cnt < lat) cnt <= cnt + 2'h1;
    else begin
      mem_rsp.ready <= 1'b1;
      mem_rsp.fault <= mem_req.addr == fault_addr;
      mem_rsp.rdata <= {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1], mem[a]};
      if (mem_req.write && mem_req.addr != fault_addr)
        {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1], mem[a]} <= mem_req.wdata;
    end
  end
endmodule // cbc_mem

// [tb_top.sv]
/* Self-checking bench for cbc_unit with the memory partner.
   Assumes 250 MHz clock and four reset cycles. */
`timescale 1ns/1ps
module tb_top;
  logic                  ref_clk, reset, req_valid, busy;
  logic [1:0]            lat;
  logic [31:0]           fault_addr, sc, s1, s2;
  logic [3:0]            f;
  cbc_pkg::cbc_req_t     req;
  cbc_pkg::cbc_out_t     res;
  cbc_pkg::cbc_mem_req_t mem_req;
  cbc_pkg::cbc_mem_rsp_t mem_rsp;
  int                    errors, n_tests, seed, i;
  cbc_unit u_cbc_unit (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req), .busy(busy), .res(res),
    .str_count(sc), .str_addr1(s1), .str_addr2(s2), .mem_req(mem_req), .mem_rsp(mem_rsp));
  cbc_mem u_cbc_mem (.ref_clk(ref_clk), .reset(reset), .mem_req(mem_req), .mem_rsp(mem_rsp), .lat(lat),
    .fault_addr(fault_addr));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic summarize();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic go(input cbc_pkg::cbc_op_t o);
    int k;
    @(posedge ref_clk) #1 req.op = o;
    req_valid = 1;
    lat = 2'($random(seed));
    @(posedge ref_clk) #1 req_valid = 0;
    for (k = 0; k < 99 && res.done !== 1'b1; k++) @(posedge ref_clk) #1;
    if (k == 99) errors++;
  endtask
  // Reference flags: dst minus src, carry is borrow
  function automatic logic [3:0] icc(input logic [31:0] d, input logic [31:0] s);
    logic [31:0] r;
    r = d - s;
    return {d < s, (d[31] ^ s[31]) & (r[31] ^ d[31]), r == 0, r[31]};
  endfunction
  function automatic logic bt(input logic [3:0] k, input logic [3:0] g);
    case (k)
      4'h0: return 1'b1;
      4'h8: return !g[3];
      4'h9: return g[3];
      4'hB: return g[2];
      4'hC: return !g[2];
      4'hD: return !g[1] & g[0];
      4'hE: return !g[0];
      4'hF: return g[1] & g[0];
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    #40000;
    errors++;
    summarize();
  end
  initial begin
    seed = 81;
    {errors, n_tests, req, req_valid, lat, reset} = '1;
    {errors, n_tests, req, req_valid, lat} = '0;
    fault_addr = '1;
    for (i = 0; i < 256; i++) u_cbc_mem.mem[i] = i[7:0];
    {u_cbc_mem.mem[16], u_cbc_mem.mem[17], u_cbc_mem.mem[18]} = 24'h909105;
    repeat (4) @(posedge ref_clk);
    #1 reset = 0;
    for (i = 0; i < 32; i++) begin
      req.a = $random(seed);
      req.b = i[2] ? req.a : $random(seed);
      req.imm_short = i[1];
      go(i[0] ? cbc_pkg::OP_CMPW : cbc_pkg::OP_CMPI);
      cmp(res.cc, icc(req.b, req.imm_short && !i[0] ? {{16{req.a[15]}}, req.a[15:0]} : req.a));
      f = res.cc;
      req.cond = i[3:0];
      {req.f_any, req.f_bad} = 2'($random(seed));
      go(cbc_pkg::OP_BRC);
      cmp(res.pc_load, bt(req.cond, f));
      go(cbc_pkg::OP_BRF);
      cmp(res.pc_load, req.cond == 4'h0 ? req.f_any : req.cond == 4'h1 && req.f_bad);
    end
    req.fa = $realtobits(1.0);
    req.fb = 64'h7FF8000000000000;
    go(cbc_pkg::OP_CMPD);
    cmp(res.cc, 4'h3);
    req.cond = 4'hF;
    go(cbc_pkg::OP_BRC);
    cmp(res.pc_load, 1'b1);
    req.fa = 64'h8000000000000000;
    req.fb = '0;
    go(cbc_pkg::OP_CMPD);
    cmp(res.cc, 4'h2);
    req.a = 32'h80;
    req.pc_next = $random(seed);
    req.target = $random(seed);
    go(cbc_pkg::OP_CALL);
    cmp(res.sp_value, 32'h7C);
    cmp(res.pc_value, req.target);
    cmp({u_cbc_mem.mem[127], u_cbc_mem.mem[126], u_cbc_mem.mem[125], u_cbc_mem.mem[124]}, req.pc_next);
    fault_addr = 32'h3C;
    req.a = 32'h40;
    go(cbc_pkg::OP_CALL);
    cmp({res.fault, res.sp_we}, 2'b10);
    fault_addr = '1;
    req.tnum = 7'h5;
    req.a = 32'hE0;
    go(cbc_pkg::OP_CALLS);
    cmp(res.pc_value, 32'h2B2A2928);
    cmp({res.ssw_value[7:0], res.psw_clear, res.sp_value[7:0]}, {8'h2C, 1'b1, 8'hD4});
    fault_addr = 32'h11;
    {req.a, req.b, req.c} = {32'h6, 32'h90, 32'h10};
    go(cbc_pkg::OP_CMPC);
    cmp({res.str_we, sc[7:0], s1[7:0], s2[7:0]}, {1'b1, 24'h059111});
    fault_addr = '1;
    {req.a, req.b, req.c} = {sc, s1, s2};
    go(cbc_pkg::OP_CMPC);
    cmp({sc[7:0], s1[7:0], s2[7:0]}, 24'h049212);
    cmp(res.cc, icc(32'h5, 32'hFFFFFF92));
    req.a = '0;
    go(cbc_pkg::OP_CMPC);
    cmp(res.cc, 4'h2);
    req.fa = $realtobits(-2.5);
    go(cbc_pkg::OP_CNVDS);
    cmp(res.wd_value, 32'hC0200000);
    for (i = 0; i < 4; i++) begin
      req.c = i;
      go(cbc_pkg::OP_CNVRDW);
      cmp(res.wd_value, -3);
      go(cbc_pkg::OP_CNVDW);
      cmp(res.wd_value, i[0] ? -2 : i[1] ? -3 : -2);
    end
    go(cbc_pkg::OP_CNVTDW);
    cmp(res.wd_value, -2);
    cmp(res.fexc, 4'h8);
    req.fa = 64'h7FF0000000000000;
    req.pc = $random(seed);
    go(cbc_pkg::OP_CNVTDW);
    cmp(res.fexc.float_invalid_flag, 1'b1);
    cmp(res.fp_trap_pc, req.pc);
    summarize();
  end
endmodule // tb_top
